// *** core/rcr_pkg.sv ***
// Package with register map, field layout and reset values of the RTC bank
package rcr_pkg;

  // Register offsets on the device's internal register port
  localparam logic [7:0] CONTROL_OFFSET = 8'h0e;
  localparam logic [7:0] FLAGS_OFFSET   = 8'h0f;
  localparam logic [7:0] CHARGER_OFFSET = 8'h10;

  // Control field positions
  localparam int CTL_OSC_RUN_N    = 7;
  localparam int CTL_BACKUP_OE    = 5;
  localparam int CTL_RATE_HI      = 4;
  localparam int CTL_RATE_LO      = 3;
  localparam int CTL_ALARM_SELECT = 2;
  localparam int CTL_A2_ENABLE    = 1;
  localparam int CTL_A1_ENABLE    = 0;

  // Flags field positions
  localparam int FLG_OSC_HALT = 7;
  localparam int FLG_ALARM_TWO = 1;
  localparam int FLG_ALARM_ONE = 0;

  // Writable bits and first power-up values
  localparam logic [7:0] CONTROL_MASK  = 8'hbf;
  localparam logic [7:0] CONTROL_RESET = 8'h18;
  localparam logic [7:0] FLAGS_RESET   = 8'h80;
  localparam logic [7:0] CHARGER_RESET = 8'h00;

  // Charger fields
  localparam logic [3:0] CHARGER_KEY   = 4'ha;
  localparam logic [1:0] DIODE_NONE    = 2'h1;
  localparam logic [1:0] DIODE_ONE     = 2'h2;
  localparam logic [1:0] RES_250       = 2'h1;
  localparam logic [1:0] RES_2K        = 2'h2;
  localparam logic [1:0] RES_4K        = 2'h3;

  // Rate select encodings
  localparam logic [1:0] RATE_1HZ   = 2'h0;
  localparam logic [1:0] RATE_4KHZ  = 2'h1;
  localparam logic [1:0] RATE_8KHZ  = 2'h2;
  localparam logic [1:0] RATE_32KHZ = 2'h3;

  // Register write/read port
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] data;
  } rcr_access_type;

  // Decoded trickle charger setup
  typedef struct packed {
    logic enable;
    logic oneDiode;
    logic [1:0] resistor;
  } rcr_charger_type;

endpackage

// *** core/rcr_regs.sv ***
// Control, flag and trickle charger registers of the serial RTC
// Notes on behaviour
// - Control bit 7 low runs the oscillator, high stops it; zero at power-up.
// - Bit 5 low tristates the combined output on power fail; high keeps it.
// - Backup output enable bit starts at zero.
// - With wave selected, rate bits pick 1Hz, 4.096k, 8.192k or 32.768kHz.
// - Both rate bits start at one, giving 32.768kHz.
// - Alarm output selected: enabled alarm matches assert output, no wave.
// - Output select low carries the square wave; it starts low.
// - Alarm two enable gates its flag onto the output; starts at zero.
// - Alarm one enable gates its flag onto the output; starts at zero.
// - Oscillator halt flag sets on the oscillator stopping edge.
// - Halt flag also sets at power-up and when software stops oscillator.
// - Halt flag holds until software writes zero; writing one does nothing.
// - Alarm two match sets flag bit 1, and output if enabled.
// - Alarm one match sets flag bit 0, and output if enabled.
// - Alarm flags clear on a written zero; a written one leaves them.
// - Charger runs only with key 1010 in the upper nibble.
// - Charger register starts all zero, charger off.
// - Diode field 01 no diode, 10 one diode; 00 and 11 disable.
// - Resistor field 01 250, 10 2k, 11 4k ohms; 00 disables.
// - Alarms are compared once per second and matching flags set.
// - Alarm output stays active until software clears the flag.
`timescale 1ns/1ps

module rcr_regs (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Register port from the serial slave
  input  wire rcr_pkg::rcr_access_type  access,
  output logic [7:0]                    readData,
  // Timekeeping side
  input  wire logic                     secondTick,
  input  wire logic                     alarmOneMatch,
  input  wire logic                     alarmTwoMatch,
  input  wire logic                     oscStopped,
  input  wire logic                     wave1Hz,
  input  wire logic                     wave4k,
  input  wire logic                     wave8k,
  input  wire logic                     wave32k,
  input  wire logic                     powerFail,
  // Oscillator control
  output logic                          oscRun,
  // Combined wave/interrupt pin
  output logic                          waveOrIrqOut,
  output logic                          waveOrIrqOe_n,
  // Trickle charger decode
  output rcr_pkg::rcr_charger_type      charger
);
  import rcr_pkg::*;

  logic [7:0] rtcControl;
  logic [7:0] rtcFlags;
  logic       oscHaltFlag;
  logic       alarmOneFlag;
  logic       alarmTwoFlag;
  logic [7:0] chargerConfig;
  logic       oscStoppedDly;
  logic       next_wave;
  logic       next_oe_n;
  rcr_charger_type next_charger;

  // Register hit for a write at a given offset
  function automatic logic hit(input rcr_access_type a,
                               input logic [7:0] off);
    return a.write && (a.addr == off);
  endfunction

  wire ctlWrite = hit(access, CONTROL_OFFSET);
  wire flgWrite = hit(access, FLAGS_OFFSET);
  wire chgWrite = hit(access, CHARGER_OFFSET);
  wire oscStopEdge = oscStopped && !oscStoppedDly;
  // Software stopping the oscillator counts as a stop event
  wire swStop = ctlWrite && access.data[CTL_OSC_RUN_N]
                && !rtcControl[CTL_OSC_RUN_N];
  wire a1Event = secondTick && alarmOneMatch;
  wire a2Event = secondTick && alarmTwoMatch;

  // Control register; bit 6 is masked so it stays zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtcControl <= CONTROL_RESET;
    end else if (ctlWrite) begin
      rtcControl <= access.data & CONTROL_MASK;
    end
  end

  // Edge history of the oscillator stop indication
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscStoppedDly <= 1'b0;
    end else begin
      oscStoppedDly <= oscStopped;
    end
  end

  // Halt flag: sticky, set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscHaltFlag <= FLAGS_RESET[FLG_OSC_HALT];
    end else if (oscStopEdge || swStop) begin
      oscHaltFlag <= 1'b1;
    end else if (flgWrite && !access.data[FLG_OSC_HALT]) begin
      oscHaltFlag <= 1'b0;
    end
  end

  // Alarm flags: match sets, written zero clears, written one keeps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmOneFlag <= FLAGS_RESET[FLG_ALARM_ONE];
      alarmTwoFlag <= FLAGS_RESET[FLG_ALARM_TWO];
    end else begin
      if (a1Event) begin
        alarmOneFlag <= 1'b1;
      end else if (flgWrite && !access.data[FLG_ALARM_ONE]) begin
        alarmOneFlag <= 1'b0;
      end
      if (a2Event) begin
        alarmTwoFlag <= 1'b1;
      end else if (flgWrite && !access.data[FLG_ALARM_TWO]) begin
        alarmTwoFlag <= 1'b0;
      end
    end
  end

  // Status byte; one driver per flag, unused bits tied low
  always_comb begin
    rtcFlags                = 8'h00;
    rtcFlags[FLG_OSC_HALT]  = oscHaltFlag;
    rtcFlags[FLG_ALARM_TWO] = alarmTwoFlag;
    rtcFlags[FLG_ALARM_ONE] = alarmOneFlag;
  end

  // Charger register holds any value; only the decode checks the key
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chargerConfig <= CHARGER_RESET;
    end else if (chgWrite) begin
      chargerConfig <= access.data;
    end
  end

  // Readback mux; unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 8'h00;
    end else if (access.read) begin
      case (access.addr)
        CONTROL_OFFSET: readData <= rtcControl;
        FLAGS_OFFSET:   readData <= rtcFlags;
        CHARGER_OFFSET: readData <= chargerConfig;
        default:        readData <= 8'h00;
      endcase
    end
  end

  // Oscillator runs while the active-low enable is clear
  assign oscRun = !rtcControl[CTL_OSC_RUN_N];

  // Pin source: wave by rate or gated alarm flags, both registered
  always_comb begin
    next_wave = 1'b1;
    if (rtcControl[CTL_ALARM_SELECT]) begin
      // Flags stay set until cleared, so the level holds with them
      next_wave = !((rtcFlags[FLG_ALARM_ONE]
                     && rtcControl[CTL_A1_ENABLE])
                    || (rtcFlags[FLG_ALARM_TWO]
                        && rtcControl[CTL_A2_ENABLE]));
    end else begin
      case (rtcControl[CTL_RATE_HI:CTL_RATE_LO])
        RATE_1HZ:   next_wave = wave1Hz;
        RATE_4KHZ:  next_wave = wave4k;
        RATE_8KHZ:  next_wave = wave8k;
        RATE_32KHZ: next_wave = wave32k;
        default:    next_wave = 1'b1;
      endcase
    end
    // Released on power fail unless backup operation is enabled
    next_oe_n = powerFail && !rtcControl[CTL_BACKUP_OE];
  end

  // Pin registers; the enable is active low, high means released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waveOrIrqOut  <= 1'b1;
      waveOrIrqOe_n <= 1'b0;
    end else begin
      waveOrIrqOut  <= next_wave;
      waveOrIrqOe_n <= next_oe_n;
    end
  end

  // Charger decode: key, diode and resistor must all be legal
  always_comb begin
    next_charger.enable =
      (chargerConfig[7:4] == CHARGER_KEY)
      && (chargerConfig[3:2] == DIODE_NONE
          || chargerConfig[3:2] == DIODE_ONE)
      && (chargerConfig[1:0] != 2'h0);
    next_charger.oneDiode = chargerConfig[3:2] == DIODE_ONE;
    next_charger.resistor = chargerConfig[1:0];
    if (!next_charger.enable) begin
      next_charger.oneDiode = 1'b0;
      next_charger.resistor = 2'h0;
    end
  end

  // Registered charger controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charger <= '0;
    end else begin
      charger <= next_charger;
    end
  end

  // Checks
  sequence s_stop_write;
    ctlWrite && access.data[CTL_OSC_RUN_N] && oscRun;
  endsequence

  a_halt_on_stop: assert property (@(posedge clk) disable iff (!rst_n)
    s_stop_write |=> rtcFlags[FLG_OSC_HALT] && !oscRun)
    else $error("halt flag not set on software stop");

  a_halt_on_edge: assert property (@(posedge clk) disable iff (!rst_n)
    oscStopped && !oscStoppedDly |=> rtcFlags[FLG_OSC_HALT])
    else $error("halt flag not set on oscillator stop");

  a_halt_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    rtcFlags[FLG_OSC_HALT] && !flgWrite |=> rtcFlags[FLG_OSC_HALT])
    else $error("halt flag dropped without a write");

  a_alarm_one_set: assert property (@(posedge clk) disable iff (!rst_n)
    secondTick && alarmOneMatch |=> rtcFlags[FLG_ALARM_ONE])
    else $error("alarm one flag not set");

  a_alarm_two_set: assert property (@(posedge clk) disable iff (!rst_n)
    secondTick && alarmTwoMatch |=> rtcFlags[FLG_ALARM_TWO])
    else $error("alarm two flag not set");

  a_alarm_one_keep: assert property (@(posedge clk) disable iff (!rst_n)
    rtcFlags[FLG_ALARM_ONE] && flgWrite && access.data[FLG_ALARM_ONE]
    |=> rtcFlags[FLG_ALARM_ONE])
    else $error("alarm one flag lost on written one");

  a_alarm_clear: assert property (@(posedge clk) disable iff (!rst_n)
    flgWrite && !access.data[FLG_ALARM_TWO] && !a2Event
    |=> !rtcFlags[FLG_ALARM_TWO])
    else $error("alarm two flag not cleared");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    rtcControl[CTL_ALARM_SELECT] && rtcControl[CTL_A1_ENABLE]
    && rtcFlags[FLG_ALARM_ONE] |=> !waveOrIrqOut)
    else $error("alarm output not asserted");

  a_pin_release: assert property (@(posedge clk) disable iff (!rst_n)
    powerFail && !rtcControl[CTL_BACKUP_OE] |=> waveOrIrqOe_n)
    else $error("pin not released on power fail");

  a_charger_key: assert property (@(posedge clk) disable iff (!rst_n)
    chargerConfig[7:4] != CHARGER_KEY |=> !charger.enable)
    else $error("charger enabled without key");

  a_unused_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rtcControl[6] == 1'b0 && rtcFlags[6:2] == 5'h00)
    else $error("unused bits not zero");

  // Wave mode selected with a given rate code
  sequence s_wave_mode(logic [1:0] rate);
    !rtcControl[CTL_ALARM_SELECT]
    && rtcControl[CTL_RATE_HI:CTL_RATE_LO] == rate;
  endsequence

  // Alarm output selected but no enabled flag is set
  sequence s_alarm_quiet;
    rtcControl[CTL_ALARM_SELECT]
    && !(rtcFlags[FLG_ALARM_ONE] && rtcControl[CTL_A1_ENABLE])
    && !(rtcFlags[FLG_ALARM_TWO] && rtcControl[CTL_A2_ENABLE]);
  endsequence

  // Charger byte with key, legal diode path and a resistor chosen
  sequence s_charger_legal;
    chargerConfig[7:4] == CHARGER_KEY
    && (chargerConfig[3:2] == DIODE_NONE || chargerConfig[3:2] == DIODE_ONE)
    && chargerConfig[1:0] != 2'h0;
  endsequence

  a_osc_run_map: assert property (@(posedge clk) disable iff (!rst_n)
    ctlWrite |=> oscRun == !$past(access.data[CTL_OSC_RUN_N]))
    else $error("oscillator enable does not follow write");

  a_backup_drive: assert property (@(posedge clk) disable iff (!rst_n)
    powerFail && rtcControl[CTL_BACKUP_OE] |=> !waveOrIrqOe_n)
    else $error("pin released with backup output enabled");

  a_wave_1hz: assert property (@(posedge clk) disable iff (!rst_n)
    s_wave_mode(RATE_1HZ) |=> waveOrIrqOut == $past(wave1Hz))
    else $error("pin does not carry the 1Hz wave");

  a_wave_4k: assert property (@(posedge clk) disable iff (!rst_n)
    s_wave_mode(RATE_4KHZ) |=> waveOrIrqOut == $past(wave4k))
    else $error("pin does not carry the 4k wave");

  a_wave_8k: assert property (@(posedge clk) disable iff (!rst_n)
    s_wave_mode(RATE_8KHZ) |=> waveOrIrqOut == $past(wave8k))
    else $error("pin does not carry the 8k wave");

  a_wave_32k: assert property (@(posedge clk) disable iff (!rst_n)
    s_wave_mode(RATE_32KHZ) |=> waveOrIrqOut == $past(wave32k))
    else $error("pin does not carry the 32k wave");

  a_alarm_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    s_alarm_quiet |=> waveOrIrqOut)
    else $error("pin active with no enabled alarm flag");

  a_irq_two: assert property (@(posedge clk) disable iff (!rst_n)
    rtcControl[CTL_ALARM_SELECT] && rtcControl[CTL_A2_ENABLE]
    && rtcFlags[FLG_ALARM_TWO] |=> !waveOrIrqOut)
    else $error("alarm two output not asserted");

  a_halt_no_set: assert property (@(posedge clk) disable iff (!rst_n)
    !rtcFlags[FLG_OSC_HALT] && !oscStopEdge && !swStop
    |=> !rtcFlags[FLG_OSC_HALT])
    else $error("halt flag set without a stop event");

  a_alarm_two_keep: assert property (@(posedge clk) disable iff (!rst_n)
    rtcFlags[FLG_ALARM_TWO] && flgWrite && access.data[FLG_ALARM_TWO]
    |=> rtcFlags[FLG_ALARM_TWO])
    else $error("alarm two flag lost on written one");

  a_one_clear: assert property (@(posedge clk) disable iff (!rst_n)
    flgWrite && !access.data[FLG_ALARM_ONE] && !a1Event
    |=> !rtcFlags[FLG_ALARM_ONE])
    else $error("alarm one flag not cleared");

  a_alarm_no_tick: assert property (@(posedge clk) disable iff (!rst_n)
    !secondTick && !rtcFlags[FLG_ALARM_ONE] && !rtcFlags[FLG_ALARM_TWO]
    |=> !rtcFlags[FLG_ALARM_ONE] && !rtcFlags[FLG_ALARM_TWO])
    else $error("alarm flag set outside the second tick");

  // Flag and enables cannot change without a write, so the level holds
  a_irq_hold: assert property (@(posedge clk) disable iff (!rst_n)
    rtcControl[CTL_ALARM_SELECT] && rtcControl[CTL_A2_ENABLE]
    && rtcFlags[FLG_ALARM_TWO] && !ctlWrite && !flgWrite
    |-> ##2 !waveOrIrqOut)
    else $error("alarm output dropped before the flag was cleared");

  a_charger_on: assert property (@(posedge clk) disable iff (!rst_n)
    s_charger_legal |=> charger.enable
    && charger.resistor == $past(chargerConfig[1:0]))
    else $error("legal charger setting not enabled");

  a_diode_off: assert property (@(posedge clk) disable iff (!rst_n)
    chargerConfig[3:2] == 2'h0 || chargerConfig[3:2] == 2'h3
    |=> !charger.enable)
    else $error("charger enabled with illegal diode field");

endmodule

// *** tb/rcr_host_model.sv ***
// Host model that reaches the RTC registers one byte at a time
`timescale 1ns/1ps

module rcr_host_model (
  // Clock and supply sense
  input  wire logic               clk,
  input  wire logic               highSupply,
  // Register port towards the device
  output rcr_pkg::rcr_access_type access
);
  import rcr_pkg::*;

  // Port idle from time zero so no strobe leaks into reset
  initial begin
    access = '0;
  end

  // One write strobe; released fields show inverted junk, not old data
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    // 250 ohms is never programmed while main supply runs high
    if (!(highSupply && addr == CHARGER_OFFSET
          && data[1:0] == RES_250)) begin
      @(posedge clk);
      access <= '{write: 1'b1, read: 1'b0, addr: addr, data: data};
      @(posedge clk);
      access <= '{write: 1'b0, read: 1'b0, addr: ~addr, data: ~data};
    end
  endtask

  // One read strobe; the bench collects the byte a cycle later
  task automatic rd(input logic [7:0] addr);
    @(posedge clk);
    access <= '{write: 1'b0, read: 1'b1, addr: addr, data: 8'h00};
    @(posedge clk);
    access <= '{write: 1'b0, read: 1'b0, addr: ~addr, data: 8'hff};
  endtask
endmodule

// *** tb/rtc_control_status_charger_regs_bench.sv ***
// Self-checking bench for the RTC control, flag and charger registers
`timescale 1ns/1ps

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module rtc_control_status_charger_regs_bench;
  import rcr_pkg::*;

  logic            clk;
  logic            rst_n;
  logic            tick;
  logic            matchOne;
  logic            matchTwo;
  logic            oscStopped;
  logic            powerFail;
  logic            highSupply;
  logic [3:0]      waves;
  logic [7:0]      readData;
  logic            oscRun;
  logic            pinOut;
  logic            pinOe_n;
  rcr_access_type  access;
  rcr_charger_type charger;
  logic            rdSeen;
  logic [7:0]      expByte;
  logic [7:0]      expQ[$];
  logic [7:0]      rnd;
  int              seed;
  int              fail_count;
  int              checks_done;
  // Charger byte in the upper part, expected decode in the low nibble
  logic [11:0]     chgTab[8] = '{12'ha59, 12'ha9d, 12'ha6a, 12'habf,
                                 12'ha10, 12'had0, 12'ha40, 12'h250};

  rcr_regs rcr_regs_i (
    .clk(clk), .rst_n(rst_n), .access(access), .readData(readData),
    .secondTick(tick), .alarmOneMatch(matchOne), .alarmTwoMatch(matchTwo),
    .oscStopped(oscStopped), .wave1Hz(waves[0]), .wave4k(waves[1]),
    .wave8k(waves[2]), .wave32k(waves[3]), .powerFail(powerFail),
    .oscRun(oscRun), .waveOrIrqOut(pinOut), .waveOrIrqOe_n(pinOe_n),
    .charger(charger));
  rcr_host_model rcr_host_model_i (
    .clk(clk), .highSupply(highSupply), .access(access));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Read data is due one cycle after the taking edge
  always @(posedge clk) begin
    rdSeen <= access.read;
  end
  always @(negedge clk) begin
    if (rdSeen === 1'b1) begin
      expByte = expQ.pop_front();
      `CHK(readData, expByte)
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rcr_host_model_i.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    rcr_host_model_i.rd(a);
  endtask
  // Pin is registered, so give it three falling edges after the cause
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse(input logic t, input logic a1, input logic a2);
    @(posedge clk);
    tick <= t;
    matchOne <= a1;
    matchTwo <= a2;
    @(posedge clk);
    tick <= 1'b0;
    matchOne <= 1'b0;
    matchTwo <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    seed = 42077;
    rst_n = 1'b0;
    tick = 1'b0;
    matchOne = 1'b0;
    matchTwo = 1'b0;
    oscStopped = 1'b0;
    powerFail = 1'b0;
    highSupply = 1'b0;
    waves = 4'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(CONTROL_OFFSET, CONTROL_RESET);
    rd(FLAGS_OFFSET, FLAGS_RESET);
    rd(CHARGER_OFFSET, CHARGER_RESET);
    rd(8'h11, 8'h00);
    `CHK(oscRun, 1'b1)
    `CHK(charger, 4'h0)
    // Written ones never set flags; only a zero clears the halt flag
    wr(FLAGS_OFFSET, 8'hff);
    rd(FLAGS_OFFSET, 8'h80);
    wr(FLAGS_OFFSET, 8'h00);
    wr(FLAGS_OFFSET, 8'hff);
    rd(FLAGS_OFFSET, 8'h00);
    // Random control bytes, unused bit reads zero
    for (int i = 0; i < 8; i++) begin
      rnd = 8'($random(seed));
      wr(CONTROL_OFFSET, rnd);
      rd(CONTROL_OFFSET, rnd & CONTROL_MASK);
      @(negedge clk);
      `CHK(oscRun, ~rnd[7])
    end
    // Oscillator stop is edge triggered: a held level does not re-set
    wr(CONTROL_OFFSET, 8'h00);
    wr(FLAGS_OFFSET, 8'h00);
    @(posedge clk);
    oscStopped <= 1'b1;
    repeat (2) @(posedge clk);
    rd(FLAGS_OFFSET, 8'h80);
    wr(FLAGS_OFFSET, 8'h00);
    rd(FLAGS_OFFSET, 8'h00);
    oscStopped <= 1'b0;
    wr(CONTROL_OFFSET, 8'h80);
    rd(FLAGS_OFFSET, 8'h80);
    wr(CONTROL_OFFSET, 8'h00);
    wr(FLAGS_OFFSET, 8'h00);
    // Alarm flags only set on the once-per-second compare
    pulse(1'b0, 1'b1, 1'b1);
    rd(FLAGS_OFFSET, 8'h00);
    pulse(1'b1, 1'b1, 1'b0);
    rd(FLAGS_OFFSET, 8'h01);
    pulse(1'b1, 1'b0, 1'b1);
    rd(FLAGS_OFFSET, 8'h03);
    wr(FLAGS_OFFSET, 8'h03);
    rd(FLAGS_OFFSET, 8'h03);
    wr(FLAGS_OFFSET, 8'h02);
    rd(FLAGS_OFFSET, 8'h02);
    // Alarm mode with waves low: pin shows only enabled flags
    wr(CONTROL_OFFSET, 8'h05);
    settle();
    `CHK(pinOut, 1'b1)
    wr(CONTROL_OFFSET, 8'h06);
    repeat (10) settle();
    `CHK(pinOut, 1'b0)
    wr(FLAGS_OFFSET, 8'h00);
    settle();
    `CHK(pinOut, 1'b1)
    // Each rate picks its own wave input
    for (int r = 0; r < 4; r++) begin
      wr(CONTROL_OFFSET, 8'(r << 3));
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        waves <= (v == 1) ? ~(4'h1 << r) : (4'h1 << r);
        settle();
        `CHK(pinOut, 1'(v == 0))
      end
    end
    // Power fail releases the pin unless backup output is enabled
    @(posedge clk);
    powerFail <= 1'b1;
    settle();
    `CHK(pinOe_n, 1'b1)
    wr(CONTROL_OFFSET, 8'h20);
    settle();
    `CHK(pinOe_n, 1'b0)
    @(posedge clk);
    powerFail <= 1'b0;
    // Charger decode over legal settings and every disabling case
    foreach (chgTab[k]) begin
      wr(CHARGER_OFFSET, chgTab[k][11:4]);
      rd(CHARGER_OFFSET, chgTab[k][11:4]);
      @(negedge clk);
      `CHK(charger, chgTab[k][3:0])
    end
    // With main supply high the host holds back a 250 ohm setting
    @(posedge clk);
    highSupply <= 1'b1;
    @(negedge clk);
    wr(CHARGER_OFFSET, 8'ha5);
    rd(CHARGER_OFFSET, 8'h25);
    highSupply <= 1'b0;
    settle();
    tally_and_finish();
  end
endmodule
